// File: inc/msp_pkg.sv
// Constants and types for the monitor sync processor
package msp_pkg;
  localparam logic [11:0] CNT_LIM = 12'hFF0;
  localparam int MCLK_KHZ = 125000;
  localparam int HCLK_KHZ = 12000;
  localparam int VCLK_KHZ = 125;
  // 12 MHz tick by fractional accumulation, 125 kHz by division
  localparam logic [7:0] ACC_INC = 8'(HCLK_KHZ / 1000);
  localparam logic [7:0] ACC_MOD = 8'(MCLK_KHZ / 1000);
  localparam logic [9:0] VDIV_LAST = 10'(MCLK_KHZ / VCLK_KHZ - 1);
  localparam int H_DEV_NS = 167;
  localparam int V_DEV_NS = 32000;
  localparam logic [11:0] H_TOL_LINE =
    12'(H_DEV_NS * HCLK_KHZ / 1000000);
  localparam logic [11:0] H_TOL = 12'(4 * H_DEV_NS * HCLK_KHZ / 1000000);
  localparam logic [11:0] V_TOL = 12'(V_DEV_NS * VCLK_KHZ / 1000000);
  localparam logic [2:0] H_LINES = 3'h4;
  localparam logic [6:0] H_POL_LINES = 7'h3C;
  localparam logic [1:0] V_POL_PN = 2'h3;
  localparam logic [1:0] V_POL_NP = 2'h2;
  localparam logic [1:0] H_PER_MEAS = 2'h3;
  localparam logic [1:0] V_PER_MEAS = 2'h2;
  localparam logic [5:0] WID_BASE = 6'h02;
  // Generator modes
  localparam logic [1:0] GEN_FREE = 2'h0;
  localparam logic [1:0] GEN_INS = 2'h1;
  localparam logic [1:0] GEN_FOLLOW = 2'h3;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_VPH = 8'h08;
  localparam logic [7:0] ADR_HPH = 8'h0C;
  localparam logic [7:0] ADR_VHPL = 8'h10;
  localparam logic [7:0] ADR_GEN = 8'h14;
  localparam logic [7:0] ADR_HFR = 8'h18;
  localparam logic [7:0] ADR_VFR = 8'h1C;
  // Field positions and writable masks
  localparam int CTRL_CSYNC = 0;
  localparam int ST_V_CHANGE_FLAG = 0;
  localparam int ST_H_CHANGE_FLAG = 1;
  localparam int GEN_H_LSB = 4;
  localparam int GEN_V_LSB = 0;
  localparam int FR_WID_LSB = 16;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam logic [31:0] GEN_MASK = 32'h0000_0033;
  localparam logic [31:0] HFR_MASK = 32'h001F_03FF;
  localparam logic [31:0] VFR_MASK = 32'h000F_0FFF;
  localparam logic [31:0] HFR_RST = 32'h0010_0300;
  localparam logic [31:0] VFR_RST = 32'h0008_0200;

  typedef struct packed {
    logic [1:0] mode;
    logic [11:0] per;
    logic [4:0] wid;
    logic [11:0] lim;
  } msp_gen_cfg_s;
endpackage

// File: rtl/msp_sync_in.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module msp_sync_in #(
  parameter int W = 2
) (
  // System
  input wire logic mclk,
  input wire logic resetn,
  // Pins and filtered levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        lvl_q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        lvl_q[i] <= s3_q[i];
      end
    end
  end
endmodule // msp_sync_in

// File: rtl/msp_pgen.sv
// Sync pulse generator: free-run, follow, follow with insertion
`timescale 1ns/100ps
module msp_pgen (
  // System
  input wire logic mclk,
  input wire logic resetn,
  // Settings
  input wire msp_pkg::msp_gen_cfg_s cfg,
  // Timebase and corrected input
  input wire logic tick_run,
  input wire logic tick_mon,
  input wire logic in_lvl,
  input wire logic in_rise,
  // Outputs
  output logic sync_q,
  output logic line_o
);
  logic [11:0] rc_q;
  logic [11:0] mc_q;
  logic [5:0] ic_q;
  logic wrap;
  logic run_lvl;
  logic ins_go;
  logic sync_d;
  wire [5:0] wid6 = {1'b0, cfg.wid} + msp_pkg::WID_BASE;

  assign wrap = ({1'b0, rc_q} + 13'h1) >= {1'b0, cfg.per}; // see [RL14]
  assign line_o = tick_run & wrap;
  assign run_lvl = {6'h0, rc_q} < {6'h0, wid6}; // see [RL16] see [RL19]
  // Substitute when the input overstays its expected period
  assign ins_go = (cfg.mode == msp_pkg::GEN_INS) & tick_mon &
                  (mc_q >= cfg.lim) & (cfg.lim != 12'h0); // see [RL22]

  always_comb begin
    case (cfg.mode) // see [RL15] see [RL18]
      msp_pkg::GEN_FREE: sync_d = run_lvl;
      msp_pkg::GEN_INS: sync_d = in_lvl | (ic_q != 6'h0);
      msp_pkg::GEN_FOLLOW: sync_d = in_lvl;
      default: sync_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rc_q <= '0;
      mc_q <= '0;
      ic_q <= '0;
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d; // see [RL13]
      if (tick_run) begin
        rc_q <= wrap ? 12'h0 : rc_q + 12'h1; // see [RL17]
      end
      if (in_rise || ins_go) begin
        mc_q <= '0;
      end else if (tick_mon && mc_q != 12'hFFF) begin
        mc_q <= mc_q + 12'h1;
      end
      if (ins_go) begin
        ic_q <= wid6;
      end else if (tick_run && ic_q != 6'h0) begin
        ic_q <= ic_q - 6'h1;
      end
    end
  end
endmodule // msp_pgen

// File: rtl/msp_sync_proc.sv
// Monitor sync processor: measurement, change detection, generators
`timescale 1ns/100ps
// What this block does
// [RL1] Horizontal period is 12 MHz cycles over four lines, 12 bits wide
// [RL2] Horizontal polarity is the level sampled at a quarter line
// [RL3] Vertical period is 125 kHz ticks between two vertical pulses
// [RL4] Vertical polarity is the level sampled at a quarter frame
// [RL5] With composite sync the vertical polarity always reads set; the code forces the sample set, so the flag sets only after 3 frames
// [RL6] Horizontal sync is absent once its counter reaches FF0
// [RL7] Vertical sync is absent once its edge timer reaches FF0
// [RL8] Horizontal change on polarity or period beyond 167 ns per line
// [RL9] Vertical change on polarity or period beyond 32 us
// [RL10] Both change flags combine into one request to the core
// [RL11] Changes must persist: 60 lines, or 3 and 2 frames
// [RL12] Both counters are 12 bits on their own timebases
// [RL13] Generated sync pulses are active high, mode set by two bits
// [RL14] Free-run line period is the 10-bit setting in 12 MHz cycles
// [RL15] Line mode 01 inserts missing pulses, 11 only follows
// [RL16] Free-run line pulse lasts code plus two 12 MHz cycles
// [RL17] Free-run frame period is line setting times frame setting
// [RL18] Frame mode 01 inserts missing pulses, 11 only follows
// [RL19] Free-run frame pulse lasts code plus two free-run lines
// [RL20] Polarity status reads 0 for positive, 1 for negative
// [RL21] Periods read as upper bytes plus one shared low-nibble byte
// [RL22] Insertion fires when no pulse comes within period plus slack
module msp_sync_proc (
  // System
  input wire logic mclk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sync inputs from the cable
  input wire logic hsync_in,
  input wire logic vsync_in,
  // Generated sync and change request
  output logic hsync_gen,
  output logic vsync_gen,
  output logic chg_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Bus slave
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] ctrl_q;
  logic [31:0] gen_q;
  logic [31:0] hfr_q;
  logic [31:0] vfr_q;
  logic [31:0] rd_mux;
  wire [7:0] adr_w = {wb_adr_i[7:2], 2'h0};
  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & ack_q;
  wire [31:0] wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_ctrl = wr & (adr_w == msp_pkg::ADR_CTRL);
  wire wr_stat = wr & (adr_w == msp_pkg::ADR_STAT);
  wire wr_gen = wr & (adr_w == msp_pkg::ADR_GEN);
  wire wr_hfr = wr & (adr_w == msp_pkg::ADR_HFR);
  wire wr_vfr = wr & (adr_w == msp_pkg::ADR_VFR);
  wire [31:0] w1c = wr_stat ? (wb_dat_i & wm) : 32'h0;
  wire csync = ctrl_q[msp_pkg::CTRL_CSYNC];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] msk);
    merge = ((old & ~wm) | (wb_dat_i & wm)) & msk;
  endfunction

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      ctrl_q <= '0;
      gen_q <= '0;
      hfr_q <= msp_pkg::HFR_RST;
      vfr_q <= msp_pkg::VFR_RST;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) rdat_q <= rd_mux;
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, msp_pkg::CTRL_MASK);
      if (wr_gen) gen_q <= merge(gen_q, msp_pkg::GEN_MASK);
      if (wr_hfr) hfr_q <= merge(hfr_q, msp_pkg::HFR_MASK);
      if (wr_vfr) vfr_q <= merge(vfr_q, msp_pkg::VFR_MASK);
    end
  end

  sequence s_req;
    req && !ack_q;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_wb_ack_once: assert property (s_req |=> s_ack_once)
    else $error("bus ack not a single cycle after request");

  // Timebases
  logic [7:0] acc_q;
  logic [9:0] vdiv_q;
  wire [7:0] acc_s = acc_q + msp_pkg::ACC_INC;
  wire tick12 = acc_s >= msp_pkg::ACC_MOD;
  wire tick125 = vdiv_q == msp_pkg::VDIV_LAST;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= '0;
      vdiv_q <= '0;
    end else begin
      acc_q <= tick12 ? acc_s - msp_pkg::ACC_MOD : acc_s;
      vdiv_q <= tick125 ? 10'h0 : vdiv_q + 10'h1;
    end
  end

  // Input levels and edges
  logic hs;
  logic vs;
  logic hs_p_q;
  logic vs_p_q;
  logic hc_p_q;
  logic vc_p_q;
  logic h_pol_q;
  logic v_pol_q;
  msp_sync_in #(.W(2)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .pin({vsync_in, hsync_in}),
    .lvl_q({vs, hs})
  );
  wire h_rise = hs & ~hs_p_q;
  wire v_rise = vs & ~vs_p_q;
  wire hc = hs ^ h_pol_q;
  wire vc = vs ^ v_pol_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hs_p_q <= 1'b0;
      vs_p_q <= 1'b0;
      hc_p_q <= 1'b0;
      vc_p_q <= 1'b0;
    end else begin
      hs_p_q <= hs;
      vs_p_q <= vs;
      hc_p_q <= hc;
      vc_p_q <= vc;
    end
  end

  function automatic logic [11:0] absd(input logic [11:0] a,
                                       input logic [11:0] b);
    absd = (a > b) ? a - b : b - a;
  endfunction

  // Horizontal measurement
  logic [11:0] hcnt_q;
  logic [11:0] hl_q;
  logic [11:0] h_per_q;
  logic [11:0] h_ref_q;
  logic [2:0] hedge_q;
  logic [6:0] hpc_q;
  logic [1:0] hpm_q;
  logic h_pres_q;
  logic h_chg_q;
  wire h_sat = hcnt_q == msp_pkg::CNT_LIM;
  wire h_meas = h_rise & (hedge_q == msp_pkg::H_LINES) & ~h_sat; // see [RL1]
  wire h_qtr = tick12 & h_pres_q & (hl_q == {4'h0, h_per_q[11:4]});
  wire h_pol_dif = h_qtr & (hs != h_pol_q); // see [RL2]
  wire h_pol_set = h_pol_dif & (hpc_q + 7'h1 == msp_pkg::H_POL_LINES);
  wire h_per_dif = h_meas & (absd(hcnt_q, h_ref_q) > msp_pkg::H_TOL);
  wire h_per_set = h_per_dif & (hpm_q + 2'h1 == msp_pkg::H_PER_MEAS);
  wire h_lost = tick12 & (hcnt_q + 12'h1 == msp_pkg::CNT_LIM) &
                (h_ref_q != msp_pkg::CNT_LIM);
  wire h_chg_set = h_pol_set | h_per_set | h_lost; // see [RL8]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hcnt_q <= '0;
      hl_q <= '0;
      h_per_q <= '0;
      h_ref_q <= '0;
      hedge_q <= '0;
      h_pres_q <= 1'b0;
    end else begin
      if (h_rise && !h_sat) begin
        hedge_q <= (hedge_q == msp_pkg::H_LINES) ? 3'h1 : hedge_q + 3'h1;
      end else if (h_sat) begin
        hedge_q <= '0;
      end
      if (h_rise && (hedge_q == 3'h0 || h_meas)) begin
        hcnt_q <= '0;
      end else if (tick12 && !h_sat) begin
        hcnt_q <= hcnt_q + 12'h1; // see [RL12]
      end
      if (h_rise) begin
        hl_q <= '0;
      end else if (tick12 && hl_q != 12'hFFF) begin
        hl_q <= hl_q + 12'h1;
      end
      if (h_meas) h_per_q <= hcnt_q;
      if (h_meas) begin
        h_pres_q <= 1'b1;
      end else if (h_sat) begin
        h_pres_q <= 1'b0; // see [RL6]
      end
      if (h_per_set) begin
        h_ref_q <= hcnt_q;
      end else if (h_lost) begin
        h_ref_q <= msp_pkg::CNT_LIM;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hpc_q <= '0;
      hpm_q <= '0;
      h_pol_q <= 1'b0;
    end else begin
      if (h_pol_set) begin
        hpc_q <= '0;
        h_pol_q <= hs; // see [RL11] see [RL20]
      end else if (h_pol_dif) begin
        hpc_q <= hpc_q + 7'h1;
      end else if (h_qtr) begin
        hpc_q <= '0;
      end
      if (h_per_set || (h_meas && !h_per_dif)) begin
        hpm_q <= '0;
      end else if (h_per_dif) begin
        hpm_q <= hpm_q + 2'h1;
      end
    end
  end

  a_h_period_count_latch: assert property (h_meas |=> h_per_q == $past(hcnt_q)) // see [RL1]
    else $error("line period not latched from counter");
  a_hcnt_sat: assert property (h_sat && !h_rise |=> h_sat) // see [RL12]
    else $error("line counter left its limit without a pulse");
  a_h_presence_flag_drop: assert property (h_sat |=> !h_pres_q) // see [RL6]
    else $error("line presence kept at counter limit");
  a_h_polarity_flag_hold: assert property ($changed(h_pol_q) |->
    $past(hpc_q) == msp_pkg::H_POL_LINES - 7'h1) // see [RL11]
    else $error("line polarity changed without 60 lines");
  a_h_period_count_tol: assert property (h_meas &&
    absd(hcnt_q, h_ref_q) <= msp_pkg::H_TOL |=> hpm_q == 2'h0) // see [RL8]
    else $error("small line drift counted as change");

  // Vertical measurement
  logic [11:0] vcnt_q;
  logic [11:0] v_per_q;
  logic [11:0] v_ref_q;
  logic [1:0] vpc_q;
  logic [1:0] vpm_q;
  logic v_seen_q;
  logic v_pres_q;
  logic v_chg_q;
  logic v_raw;
  wire v_sat = vcnt_q == msp_pkg::CNT_LIM;
  wire v_meas = v_rise & v_seen_q & ~v_sat; // see [RL3]
  wire v_qtr = tick125 & v_pres_q & (vcnt_q == {2'h0, v_per_q[11:2]});
  wire [1:0] v_need = v_pol_q ? msp_pkg::V_POL_NP : msp_pkg::V_POL_PN;
  assign v_raw = csync | vs; // see [RL4] see [RL5]
  wire v_pol_dif = v_qtr & (v_raw != v_pol_q);
  wire v_pol_set = v_pol_dif & (vpc_q + 2'h1 == v_need); // see [RL11]
  wire v_per_dif = v_meas & (absd(vcnt_q, v_ref_q) > msp_pkg::V_TOL);
  wire v_per_set = v_per_dif & (vpm_q + 2'h1 == msp_pkg::V_PER_MEAS);
  wire v_lost = tick125 & (vcnt_q + 12'h1 == msp_pkg::CNT_LIM) &
                (v_ref_q != msp_pkg::CNT_LIM);
  wire v_chg_set = v_pol_set | v_per_set | v_lost; // see [RL9]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      vcnt_q <= '0;
      v_per_q <= '0;
      v_ref_q <= '0;
      v_seen_q <= 1'b0;
      v_pres_q <= 1'b0;
    end else begin
      if (v_rise) begin
        vcnt_q <= '0; // see [RL7]
      end else if (tick125 && !v_sat) begin
        vcnt_q <= vcnt_q + 12'h1; // see [RL12]
      end
      if (v_rise) begin
        v_seen_q <= 1'b1;
      end else if (v_sat) begin
        v_seen_q <= 1'b0;
      end
      if (v_meas) v_per_q <= vcnt_q;
      if (v_meas) begin
        v_pres_q <= 1'b1;
      end else if (v_sat) begin
        v_pres_q <= 1'b0; // see [RL7]
      end
      if (v_per_set) begin
        v_ref_q <= vcnt_q;
      end else if (v_lost) begin
        v_ref_q <= msp_pkg::CNT_LIM;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      vpc_q <= '0;
      vpm_q <= '0;
      v_pol_q <= 1'b0;
    end else begin
      if (v_pol_set) begin
        vpc_q <= '0;
        v_pol_q <= v_raw; // see [RL20]
      end else if (v_pol_dif) begin
        vpc_q <= vpc_q + 2'h1;
      end else if (v_qtr) begin
        vpc_q <= '0;
      end
      if (v_per_set || (v_meas && !v_per_dif)) begin
        vpm_q <= '0;
      end else if (v_per_dif) begin
        vpm_q <= vpm_q + 2'h1;
      end
    end
  end

  a_v_period_count_latch: assert property (v_meas |=> v_per_q == $past(vcnt_q)) // see [RL3]
    else $error("frame period not latched from counter");
  a_v_presence_flag_drop: assert property (v_sat |=> !v_pres_q) // see [RL7]
    else $error("frame presence kept at counter limit");
  a_v_polarity_flag_comp: assert property (csync && v_qtr && !v_pol_q |=>
    vpc_q != 2'h0 || v_pol_q) // see [RL5]
    else $error("composite sample not taken as set");
  a_v_polarity_flag_hold: assert property ($rose(v_pol_q) |->
    $past(vpc_q) == msp_pkg::V_POL_PN - 2'h1) // see [RL11]
    else $error("frame polarity set without 3 frames");

  // Change flags, write one to clear, a new event beats the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      h_chg_q <= 1'b0;
      v_chg_q <= 1'b0;
    end else begin
      h_chg_q <= h_chg_set | (h_chg_q & ~w1c[msp_pkg::ST_H_CHANGE_FLAG]);
      v_chg_q <= v_chg_set | (v_chg_q & ~w1c[msp_pkg::ST_V_CHANGE_FLAG]);
    end
  end
  assign chg_irq = h_chg_q | v_chg_q; // see [RL10]

  a_chg_set_wins: assert property (h_chg_set && w1c[msp_pkg::ST_H_CHANGE_FLAG]
    |=> h_chg_q) // see [RL8]
    else $error("change event lost to clear");
  a_irq_follow: assert property ($rose(h_chg_q) || $rose(v_chg_q)
    |-> chg_irq [*2] or ##1 !h_chg_q && !v_chg_q) // see [RL10]
    else $error("change request not raised");

  // Read mux
  wire [7:0] stat_w = {2'h0, h_pres_q, v_pres_q, h_pol_q, v_pol_q,
                       h_chg_q, v_chg_q};
  assign rd_mux =
    (adr_w == msp_pkg::ADR_CTRL) ? ctrl_q :
    (adr_w == msp_pkg::ADR_STAT) ? {24'h0, stat_w} :
    (adr_w == msp_pkg::ADR_VPH) ? {24'h0, v_per_q[11:4]} : // see [RL21]
    (adr_w == msp_pkg::ADR_HPH) ? {24'h0, h_per_q[11:4]} :
    (adr_w == msp_pkg::ADR_VHPL) ?
      {24'h0, v_per_q[3:0], h_per_q[3:0]} :
    (adr_w == msp_pkg::ADR_GEN) ? gen_q :
    (adr_w == msp_pkg::ADR_HFR) ? hfr_q :
    (adr_w == msp_pkg::ADR_VFR) ? vfr_q : 32'h0;

  // Generators
  logic h_line;
  msp_pkg::msp_gen_cfg_s hcfg;
  msp_pkg::msp_gen_cfg_s vcfg;
  assign hcfg.mode = gen_q[msp_pkg::GEN_H_LSB +: 2]; // see [RL13]
  assign hcfg.per = {2'h0, hfr_q[9:0]}; // see [RL14]
  assign hcfg.wid = hfr_q[msp_pkg::FR_WID_LSB +: 5];
  assign hcfg.lim = {2'h0, h_per_q[11:2]} + msp_pkg::H_TOL_LINE;
  assign vcfg.mode = gen_q[msp_pkg::GEN_V_LSB +: 2];
  assign vcfg.per = vfr_q[11:0]; // see [RL17]
  assign vcfg.wid = {1'b0, vfr_q[msp_pkg::FR_WID_LSB +: 4]};
  assign vcfg.lim = v_per_q + msp_pkg::V_TOL; // see [RL22]

  msp_pgen u_hgen (
    .mclk(mclk),
    .resetn(resetn),
    .cfg(hcfg),
    .tick_run(tick12),
    .tick_mon(tick12),
    .in_lvl(hc),
    .in_rise(hc & ~hc_p_q),
    .sync_q(hsync_gen),
    .line_o(h_line)
  );

  msp_pgen u_vgen (
    .mclk(mclk),
    .resetn(resetn),
    .cfg(vcfg),
    .tick_run(h_line),
    .tick_mon(tick125),
    .in_lvl(vc),
    .in_rise(vc & ~vc_p_q),
    .sync_q(vsync_gen),
    .line_o()
  );
endmodule // msp_sync_proc

// File: test/msp_sync_src.sv
// Behavioural video source driving horizontal and vertical sync
`timescale 1ns/100ps
module msp_sync_src (
  // Clock
  input wire logic mclk,
  // Line and frame timing in mclk cycles
  input wire logic h_on,
  input wire logic [15:0] h_per,
  input wire logic [15:0] h_wid,
  input wire logic [15:0] v_per,
  input wire logic [15:0] v_wid,
  // Cable sync lines
  output logic hsync,
  output logic vsync
);
  logic [15:0] hc_q = 16'h0000;
  logic [15:0] vc_q = 16'h0000;
  always_ff @(posedge mclk) begin
    hc_q <= (hc_q >= h_per - 16'h0001) ? 16'h0000 : hc_q + 16'h0001;
    vc_q <= (vc_q >= v_per - 16'h0001) ? 16'h0000 : vc_q + 16'h0001;
  end
  // A stopped source parks its line at the inactive level
  assign hsync = h_on && (hc_q < h_wid);
  assign vsync = vc_q < v_wid;
endmodule // msp_sync_src

// File: test/test_monitor_sync_processor.sv
// Self-checking bench for the monitor sync processor
`timescale 1ns/100ps
module test_monitor_sync_processor;
  logic mclk, resetn, cyc, stb, we, mon_sel, h_on, mon;
  logic wb_ack_o, hsync_gen, vsync_gen, chg_irq, hs, vs;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rd, wb_dat_o;
  logic [15:0] h_per;
  logic [11:0] hp, vp;
  int n_fail, tests_run, w, p;

  assign mon = mon_sel ? vsync_gen : hsync_gen;

  msp_sync_src src (.mclk(mclk), .h_on(h_on), .h_per(h_per),
    .h_wid(16'h0028), .v_per(16'h2710), .v_wid(16'h012C),
    .hsync(hs), .vsync(vs));

  msp_sync_proc DUT (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .hsync_in(hs), .vsync_in(vs), .hsync_gen(hsync_gen),
    .vsync_gen(vsync_gen), .chg_irq(chg_irq));

  task stop_test;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task fail(input string m);
    n_fail++;
    $display("ERROR at %0t: %s", $time, m);
  endtask

  task chk_eq(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) fail(m);
  endtask

  task chk_rng(input logic [31:0] g, input int lo, input int hi,
               input string m);
    tests_run++;
    if (^g === 1'bx || g < lo || g > hi) fail(m);
  endtask

  // Classic single cycle; the answer is taken at the edge that sees ack
  task bus(input logic w_i, input logic [7:0] a, input logic [3:0] s,
           input logic [31:0] d);
    int i;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_i;
    adr <= a;
    sel <= s;
    wdat <= d;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 16);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (i >= 16) begin
      fail("no bus ack");
      stop_test();
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
           input string s);
    bus(1'b0, a, 4'h0, 32'h0000_0000);
    chk_eq(rd & m, e, s);
  endtask

  task step(inout int n);
    @(posedge mclk);
    n++;
  endtask

  // Width and rise-to-rise period of a generated pulse, in mclk cycles
  task meas(input logic s, output int wo, output int po);
    int n, r;
    mon_sel = s;
    n = 0;
    while (mon !== 1'b0 && n < 40000) step(n);
    while (mon !== 1'b1 && n < 40000) step(n);
    r = n;
    while (mon === 1'b1 && n < 40000) step(n);
    wo = n - r;
    while (mon !== 1'b1 && n < 40000) step(n);
    po = n - r;
    if (n >= 40000) begin
      fail("no generated pulse");
      stop_test();
    end
  endtask

  function int t2c(input int ticks);
    return ticks * 125 / 12;
  endfunction

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    mon_sel = 1'b0;
    h_on = 1'b1;
    h_per = 16'h01F4;
    n_fail = 0;
    tests_run = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rdc(8'h00, 32'hFFFF_FFFF, 32'h0000_0000, "control reset value");
    rdc(8'h14, 32'hFFFF_FFFF, 32'h0000_0000, "generator reset value");
    rdc(8'h18, 32'hFFFF_FFFF, 32'h0010_0300, "line setting reset");
    bus(1'b1, 8'h1C, 4'h1, 32'hFFFF_FFFF);
    rdc(8'h1C, 32'hFFFF_FFFF, 32'h0008_02FF, "frame setting lane write");
    bus(1'b1, 8'h20, 4'hF, 32'hFFFF_FFFF);
    rdc(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    $display("test registers finished at %0t", $time);
    // Free run: 100 ticks a line, width code 3, four lines a frame
    bus(1'b1, 8'h18, 4'hF, 32'h0003_0064);
    bus(1'b1, 8'h1C, 4'hF, 32'h0000_0004);
    repeat (1200) @(posedge mclk);
    meas(1'b0, w, p);
    chk_rng(w, t2c(5) - 2, t2c(5) + 2, "h free width");
    chk_rng(p, t2c(100) - 2, t2c(100) + 2, "h free period");
    meas(1'b1, w, p);
    chk_rng(w, t2c(200) - 4, t2c(200) + 4, "v free width");
    chk_rng(p, t2c(400) - 4, t2c(400) + 4, "v free period");
    $display("test free run finished at %0t", $time);
    bus(1'b1, 8'h14, 4'hF, 32'h0000_0033);
    meas(1'b0, w, p);
    chk_rng(w, 39, 41, "h follow width");
    chk_rng(p, 499, 501, "h follow period");
    meas(1'b1, w, p);
    chk_rng(w, 299, 301, "v follow width");
    chk_rng(p, 9999, 10001, "v follow period");
    $display("test follow finished at %0t", $time);
    rdc(8'h04, 32'h0000_003C, 32'h0000_0030, "presence, polarity");
    bus(1'b0, 8'h0C, 4'h0, 32'h0000_0000);
    hp[11:4] = rd[7:0];
    bus(1'b0, 8'h08, 4'h0, 32'h0000_0000);
    vp[11:4] = rd[7:0];
    bus(1'b0, 8'h10, 4'h0, 32'h0000_0000);
    hp[3:0] = rd[3:0];
    vp[3:0] = rd[7:4];
    chk_rng({20'h00000, hp}, 189, 193, "h period");
    chk_rng({20'h00000, vp}, 9, 11, "v period");
    $display("test measurement finished at %0t", $time);
    bus(1'b1, 8'h04, 4'hF, 32'h0000_0003);
    rdc(8'h04, 32'h0000_0003, 32'h0000_0000, "change cleared");
    chk_eq(chg_irq, 1'b0, "request idle");
    h_per <= 16'h01F5;
    repeat (6000) @(posedge mclk);
    rdc(8'h04, 32'h0000_0003, 32'h0000_0000, "small drift");
    h_per <= 16'h0258;
    repeat (12000) @(posedge mclk);
    rdc(8'h04, 32'h0000_0002, 32'h0000_0002, "period change");
    chk_eq(chg_irq, 1'b1, "change request");
    $display("test change finished at %0t", $time);
    bus(1'b1, 8'h14, 4'hF, 32'h0000_0013);
    bus(1'b1, 8'h00, 4'hF, 32'h0000_0001);
    h_on <= 1'b0;
    meas(1'b0, w, p);
    meas(1'b0, w, p);
    chk_rng(p, 560, 680, "inserted spacing");
    repeat (45000) @(posedge mclk);
    rdc(8'h04, 32'h0000_0034, 32'h0000_0014, "absent, forced");
    $display("test absence finished at %0t", $time);
    stop_test();
  end
endmodule // test_monitor_sync_processor
